// ==== logic/ida_pkg.sv ====
package ida_pkg;

    // Behaviour
    // - size field times four gives kilobytes
    // - type field codes none, rom, flash, fast flash
    // - supply volts equal twenty times code over 256
    // - high voltage field always reads zero
    // - high voltage byte above supply code byte
    // - identification words ignore every software write
    // - contents final only after flash init
    // - access select high at reset means ready
    // - poll bits fifteen, fourteen low once ready
    // - defaults f040h and 0040h before init done
    // - revision word readable at f07ch

    // byte addresses on the bus (16-bit address space)
    localparam logic [15:0] IDA_ADDR_MEMID = 16'hf074;
    localparam logic [15:0] IDA_ADDR_PROG = 16'hf078;
    localparam logic [15:0] IDA_ADDR_CHIP = 16'hf07c;

    // field positions
    localparam int IDA_SIZE_LSB = 0;
    localparam int IDA_TYPE_LSB = 12;
    localparam int IDA_POLL_HI = 15;
    localparam int IDA_POLL_LO = 14;
    localparam int IDA_SUPPLY_LSB = 0;
    localparam int IDA_VPP_LSB = 8;

    // memory type codes, 4h..fh reserved
    localparam logic [3:0] IDA_TYPE_NONE = 4'h0;
    localparam logic [3:0] IDA_TYPE_MROM = 4'h1;
    localparam logic [3:0] IDA_TYPE_SFLASH = 4'h2;
    localparam logic [3:0] IDA_TYPE_HFLASH = 4'h3;

    // size in units of four kilobytes: 256 kbyte
    localparam logic [11:0] IDA_MEM_SIZE = 12'h040;
    localparam int IDA_SIZE_UNIT_KB = 4;
    localparam int IDA_MEM_KB = 256;

    // supply code: volts = 20 * code / 256, 40h gives 5 v
    localparam logic [7:0] IDA_SUPPLY_CODE = 8'h40;
    localparam int IDA_SUPPLY_MUL = 20;
    localparam int IDA_SUPPLY_DIV = 256;
    localparam logic [7:0] IDA_VPP_CODE = 8'h00;

    // values shown before flash init completes
    localparam logic [15:0] IDA_MEMID_DFLT = 16'hf040;
    localparam logic [15:0] IDA_PROG_DFLT = 16'h0040;
    localparam logic [15:0] IDA_CHIP_DFLT = 16'h0000;
    // revision code: value is arbitrary
    localparam logic [15:0] IDA_CHIP_REV = 16'h0a05;

    localparam logic [31:0] IDA_RDATA_RST = 32'h0000_0000;

    // register selector
    typedef enum logic [1:0] {
        IDA_SEL_MEMID,
        IDA_SEL_PROG,
        IDA_SEL_CHIP,
        IDA_SEL_NONE
    } ida_sel_e;

    // address decode, used by slave and checks
    function automatic ida_sel_e ida_decode(input logic [15:0] a);
        ida_sel_e s;
        s = IDA_SEL_NONE;
        if (a == IDA_ADDR_MEMID) s = IDA_SEL_MEMID;
        if (a == IDA_ADDR_PROG) s = IDA_SEL_PROG;
        if (a == IDA_ADDR_CHIP) s = IDA_SEL_CHIP;
        return s;
    endfunction

    // memory identity layout: type over size
    function automatic logic [15:0] ida_memid(input logic [3:0] t,
                                              input logic [11:0] s);
        return {t, s};
    endfunction

    // programming voltage layout: vpp byte over supply byte
    function automatic logic [15:0] ida_prog(input logic [7:0] vpp,
                                             input logic [7:0] sup);
        return {vpp, sup};
    endfunction

endpackage

// ==== logic/ida_init_track.sv ====
`timescale 1ns/1ps
// tracks whether the flash has finished initialising
module ida_init_track (
    input wire logic clk,
    input wire logic rstn,
    input wire logic flash_init_done,
    input wire logic external_access_select,
    output logic done_now,
    output logic done_r
);
    // high during reset and in the first cycle after its release
    logic first_r;

    // strap taken at the first edge after release, not in reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // done as seen this very cycle, so words switch at once
    always_comb begin
        done_now = done_r | flash_init_done;
        // booting from internal memory: flash is ready already
        if (first_r && external_access_select) begin
            done_now = 1'b1;
        end
    end

    // sticky: init never un-completes until the next reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_now;
        end
    end
endmodule

// ==== logic/ida_word_build.sv ====
`timescale 1ns/1ps
// builds the three identification words from the init state
module ida_word_build (
    input wire logic done,
    input wire logic [15:0] chip_rev,
    output logic [15:0] memid_w,
    output logic [15:0] prog_w,
    output logic [15:0] chip_w
);
    // contents are only final once the flash is ready
    always_comb begin
        memid_w = ida_pkg::IDA_MEMID_DFLT;
        prog_w = ida_pkg::IDA_PROG_DFLT;
        chip_w = ida_pkg::IDA_CHIP_DFLT;
        if (done) begin
            // fast flash type keeps poll bits 15:14 low
            memid_w = ida_pkg::ida_memid(ida_pkg::IDA_TYPE_HFLASH,
                                         ida_pkg::IDA_MEM_SIZE);
            prog_w = ida_pkg::ida_prog(ida_pkg::IDA_VPP_CODE,
                                       ida_pkg::IDA_SUPPLY_CODE);
            chip_w = chip_rev;
        end
    end
endmodule

// ==== logic/ida_bank.sv ====
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// identification register bank behind an apb slave port
module ida_bank #(
    parameter logic [15:0] CHIP_REV = ida_pkg::IDA_CHIP_REV
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic flash_init_done,
    input wire logic external_access_select,
    output logic init_complete
);

    // slave states: waiting for an access, or answering it
    typedef enum logic {
        IDA_ST_IDLE,
        IDA_ST_RESP
    } ida_state_e;

    ida_state_e state_r; // slave state
    ida_state_e state_nxt; // next slave state
    logic done_now; // init done as seen this cycle
    logic done_r; // sticky init done
    logic [15:0] memid_w; // memory identity word
    logic [15:0] prog_w; // programming voltage word
    logic [15:0] chip_w; // chip revision word
    logic [15:0] rd_word; // word picked by the address
    ida_pkg::ida_sel_e sel; // decoded register
    logic access; // access phase of a transfer
    logic wdata_unused; // write data is never stored

    // flash init tracking, including the strap case
    ida_init_track u_track (
        .clk(clk),
        .rstn(rstn),
        .flash_init_done(flash_init_done),
        .external_access_select(external_access_select),
        .done_now(done_now),
        .done_r(done_r)
    );

    // word contents follow done_now, not done_r, so a read in the
    // cycle done first rises already shows the final values
    ida_word_build u_words (
        .done(done_now),
        .chip_rev(CHIP_REV),
        .memid_w(memid_w),
        .prog_w(prog_w),
        .chip_w(chip_w)
    );

    // decode once, reused by the read mux and the error flag
    assign sel = ida_pkg::ida_decode(paddr);
    assign access = psel & penable;
    // software writes land nowhere: there is no storage to hit
    assign wdata_unused = ^pwdata;

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_word = 16'h0000;
        unique case (sel)
            ida_pkg::IDA_SEL_MEMID: rd_word = memid_w;
            ida_pkg::IDA_SEL_PROG: rd_word = prog_w;
            ida_pkg::IDA_SEL_CHIP: rd_word = chip_w;
            ida_pkg::IDA_SEL_NONE: rd_word = 16'h0000;
        endcase
    end

    // one wait state: pready comes from a flip-flop, which costs a
    // cycle per transfer but keeps every output registered
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IDA_ST_IDLE: begin
                // answer on the first access-phase edge
                if (access) begin
                    state_nxt = IDA_ST_RESP;
                end
            end
            IDA_ST_RESP: begin
                // master sees pready now and releases the transfer
                state_nxt = IDA_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= IDA_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // pready high for exactly the completing cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
        end else begin
            pready <= (state_r == IDA_ST_IDLE) && access;
        end
    end

    // read data captured with pready; writes only get a response
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= ida_pkg::IDA_RDATA_RST;
        end else if ((state_r == IDA_ST_IDLE) && access) begin
            if (pwrite) begin
                // read-only bank: write data is dropped
                prdata <= ida_pkg::IDA_RDATA_RST;
            end else begin
                // narrow word in the low bits, upper bits zero
                prdata <= {16'h0000, rd_word};
            end
        end else begin
            prdata <= ida_pkg::IDA_RDATA_RST;
        end
    end

    // error only for unmapped addresses; writes to a mapped word
    // complete quietly so boot code may probe without a fault
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pslverr <= 1'b0;
        end else if ((state_r == IDA_ST_IDLE) && access) begin
            pslverr <= (sel == ida_pkg::IDA_SEL_NONE);
        end else begin
            pslverr <= 1'b0;
        end
    end

    // status pin mirrors the sticky done
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            init_complete <= 1'b0;
        end else begin
            init_complete <= done_now;
        end
    end

    // helper state for the checks below: what the answer came from
    ida_pkg::ida_sel_e ans_sel_r; // register of the pending answer
    logic ans_done_r; // init state when the answer was taken
    logic ans_write_r; // answer belongs to a write
    logic first_r; // first cycle after reset release
    logic [15:0] memid_last_r; // memory word a cycle earlier

    // capture the cause of each answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ans_sel_r <= ida_pkg::IDA_SEL_NONE;
            ans_done_r <= 1'b0;
            ans_write_r <= 1'b0;
        end else if ((state_r == IDA_ST_IDLE) && access) begin
            ans_sel_r <= sel;
            ans_done_r <= done_now;
            ans_write_r <= pwrite;
        end
    end

    // first-cycle marker and word history
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_r <= 1'b1;
            memid_last_r <= ida_pkg::IDA_MEMID_DFLT;
        end else begin
            first_r <= 1'b0;
            memid_last_r <= memid_w;
        end
    end

    // a completed read answer
    sequence s_read_done;
        pready && !ans_write_r;
    endsequence

    // setup then one access edge then pready
    sequence s_apb_turn;
        (psel && !penable) ##1 (access && !pready) ##1 pready;
    endsequence

    // memory size field gives 256 kbyte once ready
    a_size_field: assert property (@(posedge clk) disable iff (!rstn)
        s_read_done && ans_sel_r == ida_pkg::IDA_SEL_MEMID && ans_done_r
        |-> (int'(prdata[11:0]) * ida_pkg::IDA_SIZE_UNIT_KB
             == ida_pkg::IDA_MEM_KB))
        else $error("memory size field wrong");

    // memory type field carries a non-reserved code
    a_type_field: assert property (@(posedge clk) disable iff (!rstn)
        s_read_done && ans_sel_r == ida_pkg::IDA_SEL_MEMID && ans_done_r
        |-> prdata[15:12] == ida_pkg::IDA_TYPE_HFLASH)
        else $error("memory type field wrong");

    // supply code gives five volts
    a_supply_code: assert property (@(posedge clk) disable iff (!rstn)
        s_read_done && ans_sel_r == ida_pkg::IDA_SEL_PROG
        |-> (int'(prdata[7:0]) * ida_pkg::IDA_SUPPLY_MUL
             / ida_pkg::IDA_SUPPLY_DIV == 5))
        else $error("supply code wrong");

    // high voltage byte always zero
    a_vpp_zero: assert property (@(posedge clk) disable iff (!rstn)
        s_read_done && ans_sel_r == ida_pkg::IDA_SEL_PROG
        |-> prdata[15:8] == 8'h00)
        else $error("high voltage field not zero");

    // programming word layout and upper half zero
    a_prog_layout: assert property (@(posedge clk) disable iff (!rstn)
        s_read_done && ans_sel_r == ida_pkg::IDA_SEL_PROG && ans_done_r
        |-> prdata == {16'h0000, ida_pkg::IDA_VPP_CODE,
                       ida_pkg::IDA_SUPPLY_CODE})
        else $error("programming word layout wrong");

    // writes return no data and leave the memory identity word untouched
    a_write_ignored: assert property (@(posedge clk) disable iff (!rstn)
        pready && ans_write_r
        |-> prdata == 32'h0000_0000 && memid_w == memid_last_r
            || $rose(done_r))
        else $error("write disturbed the bank");

    // before init the memory and programming words show their defaults
    a_init_gate: assert property (@(posedge clk) disable iff (!rstn)
        !done_now |-> memid_w == ida_pkg::IDA_MEMID_DFLT
            && prog_w == ida_pkg::IDA_PROG_DFLT)
        else $error("final values shown before init");

    // strap high at release means ready from the first cycle
    a_strap_ready: assert property (@(posedge clk) disable iff (!rstn)
        first_r && external_access_select
        |-> done_now ##1 init_complete)
        else $error("strap boot not ready at once");

    // poll bits low exactly when init had completed
    a_poll_bits: assert property (@(posedge clk) disable iff (!rstn)
        s_read_done && ans_sel_r == ida_pkg::IDA_SEL_MEMID
        |-> (prdata[15:14] == 2'b00) == ans_done_r)
        else $error("poll bits disagree with init");

    // default read values before init
    a_default_read: assert property (@(posedge clk) disable iff (!rstn)
        s_read_done && !ans_done_r
        && ans_sel_r != ida_pkg::IDA_SEL_NONE
        |-> prdata[15:0] == ida_pkg::IDA_MEMID_DFLT
            || prdata[15:0] == ida_pkg::IDA_PROG_DFLT
            || prdata[15:0] == ida_pkg::IDA_CHIP_DFLT)
        else $error("default value wrong");

    // revision word answers at its address
    a_chip_read: assert property (@(posedge clk) disable iff (!rstn)
        s_read_done && ans_sel_r == ida_pkg::IDA_SEL_CHIP && ans_done_r
        |-> prdata == {16'h0000, CHIP_REV} && !pslverr)
        else $error("revision word wrong");

    // memory word switches to its final value in the cycle done rises
    a_switch_now: assert property (@(posedge clk) disable iff (!rstn)
        flash_init_done && !done_r
        |-> memid_w == ida_pkg::ida_memid(ida_pkg::IDA_TYPE_HFLASH,
                                          ida_pkg::IDA_MEM_SIZE)
            && prog_w != ida_pkg::IDA_PROG_DFLT - 16'h0001)
        else $error("words did not switch at once");

    // every transfer answers one edge after its access phase starts
    a_apb_turn: assert property (@(posedge clk) disable iff (!rstn)
        (psel && !penable && !pready) ##1 access |-> ##1 pready)
        else $error("answer late");

    // no answer without a transfer in progress
    a_no_stray: assert property (@(posedge clk) disable iff (!rstn)
        pready |-> $past(access) && !$past(pready))
        else $error("stray pready");

    // unmapped reads flag an error with zero data
    a_unmapped: assert property (@(posedge clk) disable iff (!rstn)
        pready && ans_sel_r == ida_pkg::IDA_SEL_NONE
        |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");

endmodule

// ==== tb/ida_bank_test.sv ====
`timescale 1ns/1ps
// self-checking bench for the identification register bank
module ida_bank_test;
    // revision code handed to the bank: value is arbitrary
    localparam logic [15:0] TB_REV = 16'h5a3c;
    // final words worked out from the field rules
    localparam logic [15:0] MEMID_FIN = {4'h3, 12'(256 / 4)};
    localparam logic [15:0] PROG_FIN = {8'h00, 8'(5 * 256 / 20)};

    // one table row: address, word before and after init, error flag
    typedef struct {
        logic [15:0] addr;
        logic [31:0] pre;
        logic [31:0] post;
        logic err;
    } ida_row_s;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic flash_init_done = 1'b0;
    logic external_access_select = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic init_complete;
    int err_total = 0; // mismatches seen
    int n_compared = 0; // comparisons made
    ida_row_s rows [5]; // ordinary read cases
    logic [31:0] rd; // data of the last transfer
    logic er; // error flag of the last transfer

    ida_bank #(.CHIP_REV(TB_REV)) dut (
        .clk(clk),
        .rstn(rstn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .flash_init_done(flash_init_done),
        .external_access_select(external_access_select),
        .init_complete(init_complete)
    );

    // 40 mhz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // prints the verdict and ends the run
    task automatic give_verdict;
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // compares one value, four-state exact
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // resets the bank with the given strap level, held for 12 cycles
    task automatic do_reset(input logic strap);
        rstn <= 1'b0;
        external_access_select <= strap;
        flash_init_done <= 1'b0;
        repeat (12) @(posedge clk);
        chk({prdata[31:0]}, 32'h0);
        chk(32'({pready, pslverr, init_complete}), 32'h0);
        rstn <= 1'b1;
        @(posedge clk);
    endtask

    // one apb transfer, entered right after a rising edge;
    // mid raises flash init done together with the access phase
    task automatic apb(input logic [15:0] a, input logic wr,
                       input logic [31:0] wd, input logic mid);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        if (mid) begin
            flash_init_done <= 1'b1;
        end
        @(posedge clk);
        // ready is sampled before this edge's updates land
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 16) begin
            err_total++;
            give_verdict();
        end
    endtask

    // main sequence: table first, then the awkward cases
    initial begin
        rows[0] = '{16'hf074, 32'h0000_f040, {16'h0, MEMID_FIN}, 1'b0};
        rows[1] = '{16'hf078, 32'h0000_0040, {16'h0, PROG_FIN}, 1'b0};
        rows[2] = '{16'hf07c, 32'h0000_0000, {16'h0, TB_REV}, 1'b0};
        rows[3] = '{16'hf070, 32'h0, 32'h0, 1'b1};
        rows[4] = '{16'hf080, 32'h0, 32'h0, 1'b1};
        do_reset(1'b0);
        // pass 0 before flash init, pass 1 after
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 5; i++) begin
                apb(rows[i].addr, 1'b0, 32'h0, 1'b0);
                chk(rd, p ? rows[i].post : rows[i].pre);
                chk(32'(er), 32'(rows[i].err));
                if (i == 0) begin
                    chk(32'(rd[15:14]), p ? 32'h0 : 32'h3);
                end
                // writes must leave the written word as it was
                apb(rows[i].addr, 1'b1, 32'hffff_ffff, 1'b0);
                chk(32'(er), 32'(rows[i].err));
                apb(rows[i].addr, 1'b0, 32'h0, 1'b0);
                chk(rd, p ? rows[i].post : rows[i].pre);
            end
            if (p == 0) begin
                chk(32'(init_complete), 32'h0);
                // a one-cycle done pulse must be remembered
                flash_init_done <= 1'b1;
                @(posedge clk);
                flash_init_done <= 1'b0;
                chk(32'(init_complete), 32'h0);
                @(posedge clk);
                chk(32'(init_complete), 32'h1);
            end
        end
        // done rises in the access phase: the taking edge sees it
        do_reset(1'b0);
        chk(32'(init_complete), 32'h0);
        apb(16'hf074, 1'b0, 32'h0, 1'b1);
        chk(rd, {16'h0, MEMID_FIN});
        flash_init_done <= 1'b0;
        apb(16'hf078, 1'b0, 32'h0, 1'b0);
        chk(rd, {16'h0, PROG_FIN});
        chk(32'(init_complete), 32'h1);
        // strap high during reset: words final at once, no done input
        do_reset(1'b1);
        @(posedge clk);
        chk(32'(init_complete), 32'h1);
        apb(16'hf074, 1'b0, 32'h0, 1'b0);
        chk(rd, {16'h0, MEMID_FIN});
        apb(16'hf07c, 1'b0, 32'h0, 1'b0);
        chk(rd, {16'h0, TB_REV});
        // strap low again: back to defaults after a fresh reset
        do_reset(1'b0);
        apb(16'hf074, 1'b0, 32'h0, 1'b0);
        chk(rd, 32'h0000_f040);
        give_verdict();
    end
endmodule
